// [design/ts_sublayer_params.svh]
// Constants for the transport sublayer receiver: offsets, fields, resets
`ifndef TS_SUBLAYER_PARAMS_SVH
`define TS_SUBLAYER_PARAMS_SVH
// ----------------------------------------
// Sublayer-subtype attribute
// ----------------------------------------
`define AVP_MANDATORY  1'b1
`define AVP_LENGTH     10'h008
`define AVP_ATTR_TYPE  16'h0011
// ----------------------------------------
// Sublayer header, first byte is sent first
// ----------------------------------------
`define HDR_V_BIT      7
`define HDR_S_BIT      6
`define HDR_H_MSB      5
`define HDR_H_LSB      4
`define HDR_FLOW_MSB   2
`define HDR_RSV_IDX    2'h1
`define HDR_SEQHI_IDX  2'h2
`define HDR_LAST_IDX   2'h3
`define H_DATA         2'h0
`define H_LATENCY      2'h1
// ----------------------------------------
// Transport stream segment
// ----------------------------------------
`define TS_LAST_IDX    8'hBB
`define TS_PIDHI_IDX   8'h01
`define TS_PIDLO_IDX   8'h02
`define TS_PIDHI_MSB   4
`define TS_NULL_PID    13'h1FFF
// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define REG_CTRL       8'h00
`define REG_SUBTYPE    8'h04
`define REG_STATUS     8'h08
`define REG_AVP_WORD0  8'h0C
`define REG_AVP_WORD1  8'h10
`define REG_CNT_BASE   8'h14
`define REG_LAST_SEQ   8'h28
`define CTRL_EN        0
`define CTRL_DROP_NULL 1
`define CTRL_LARGE_MTU 2
`define CTRL_FLOW_LSB  3
`define CTRL_FLOW_MSB  5
`define CTRL_RESET     6'h00
`define SUBTYPE_RESET  16'h0001
`endif

// [design/ts_sublayer_pkg.sv]
// Types shared by the transport sublayer receiver modules
`default_nettype none
package ts_sublayer_pkg;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_HDR  = 4'b0010,
        S_PAY  = 4'b0100,
        S_DROP = 4'b1000
    } rx_state_t;

    typedef enum logic [15:0] {
        ST_TS_SINGLE     = 16'h0001,
        ST_STREAM_LEGACY = 16'h0002,
        ST_TS_MULTI      = 16'h0003,
        ST_STREAM_MULTI  = 16'h0004,
        ST_US_SCQAM      = 16'h0006,
        ST_US_OFDMA      = 16'h0007,
        ST_US_BWREQ_SC   = 16'h0008,
        ST_US_BWREQ_OF   = 16'h0009,
        ST_US_PROBE      = 16'h000A,
        ST_US_RNG_SC     = 16'h000B,
        ST_US_RNG_OF     = 16'h000C,
        ST_DS_MAP_SC     = 16'h000D,
        ST_DS_MAP_OF     = 16'h000E,
        ST_US_SPECTRUM   = 16'h000F,
        ST_DS_PNM        = 16'h0010,
        ST_US_OOB_RET1   = 16'h0012,
        ST_DS_OOB_FWD    = 16'h0013,
        ST_US_OOB_RET2   = 16'h0014,
        ST_DS_NB_FWD     = 16'h0015,
        ST_US_NB_RET     = 16'h0016
    } subtype_code_t;
endpackage
`default_nettype wire

// [design/subtype_if.sv]
// Carrier between the receiver and its subtype classifier
`default_nettype none
interface subtype_if;
    logic [15:0] code;
    logic        valid;
    logic        is_mpeg;
    logic        is_single;
    logic        is_down;
    modport classify(input code, output valid, is_mpeg, is_single, is_down);
    modport user(output code, input valid, is_mpeg, is_single, is_down);
endinterface
`default_nettype wire

// [design/ts_subtype_classify.sv]
// Classifier of sublayer-subtype codes into direction and header family
`default_nettype none
module ts_subtype_classify
    import ts_sublayer_pkg::*;
(
    subtype_if.classify st
);
    // ----------------------------------------
    // Code table; unknown and reserved codes are invalid
    // ----------------------------------------
    always_comb begin
        st.valid     = 1'b1;
        st.is_mpeg   = 1'b0;
        st.is_single = 1'b0;
        st.is_down   = 1'b1;
        case (subtype_code_t'(st.code))
            ST_TS_SINGLE: begin                       // R2
                st.is_mpeg   = 1'b1;
                st.is_single = 1'b1;
            end
            ST_TS_MULTI, ST_DS_OOB_FWD: begin         // R2 R4
                st.is_mpeg = 1'b1;
            end
            // Streaming families carry MAC frames or link-channel data
            ST_STREAM_LEGACY, ST_STREAM_MULTI, ST_DS_MAP_SC, ST_DS_MAP_OF, ST_DS_PNM, ST_DS_NB_FWD: begin // R11 R4
                st.is_mpeg = 1'b0;
            end
            ST_US_SCQAM, ST_US_OFDMA, ST_US_BWREQ_SC, ST_US_BWREQ_OF, ST_US_PROBE, ST_US_RNG_SC,
            ST_US_RNG_OF, ST_US_SPECTRUM, ST_US_NB_RET: begin // R3
                st.is_down = 1'b0;
            end
            ST_US_OOB_RET1, ST_US_OOB_RET2: begin     // R3
                st.is_mpeg = 1'b1;
                st.is_down = 1'b0;
            end
            default: begin                            // R4
                st.valid   = 1'b0;
                st.is_down = 1'b0;
            end
        endcase
    end
endmodule // ts_subtype_classify
`default_nettype wire

// [design/ts_sublayer_rx.sv]
// Receiver of single-channel transport sublayer packets with APB registers
//
// Overview of operation
// R1: Subtype attribute: type 17, length 8, vendor
// R2: Downstream codes 1 to 4 by family
// R3: Upstream codes 6-12, 15, 18, 20, 22
// R4: Codes 13,14,16,19,21 downstream; 5,17 reserved
// R5: Headend sends subtype attribute in setup messages
// R6: Device replies with subtype matching its session
// R7: Headend frames data with negotiated header
// R8: Wrong session type requests session teardown
// R9: Non-conforming headers are silently dropped
// R10: Payload is whole 188-byte segments
// R11: Streaming subtypes carry frames, not segments
// R12: Header: V, S, H, X, flow, reserved, sequence
// R13: Sequence used only when valid flag set
// R14: Extended bits 00 mean data header
// R15: X bit and reserved byte ignored
// R16: Sequence gaps reveal lost packets
// R17: Headend inserts no filler between segments
// R18: Headend supports every header bit
// R19: Accept one to seven segments per packet
// R20: More segments only with larger path MTU
// R21: Null segments may be discarded
// R22: Only one flow identifier supported
// R23: Extended bits 01 latency; 10, 11 invalid
// R24: Sequence sent high byte first
`default_nettype none
`include "ts_sublayer_params.svh"
module ts_sublayer_rx
    import ts_sublayer_pkg::*;
#(
    parameter int          MAX_TS_STD   = 7,
    parameter int          MAX_TS_LARGE = 64,
    parameter logic [15:0] VENDOR_ID    = 16'hA5A5  // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic        pready,
    output var  logic [31:0] prdata,
    output var  logic        pslverr,
    input  wire logic        in_valid,
    input  wire logic [7:0]  in_data,
    input  wire logic        in_sop,
    input  wire logic        in_eop,
    output var  logic        in_ready,
    output var  logic        ts_valid,
    output var  logic [7:0]  ts_data,
    output var  logic        ts_sos,
    output var  logic        ts_eos,
    output var  logic        pkt_done,
    output var  logic        pkt_err,
    output var  logic        teardown_request
);
    localparam int CNT_N    = 5;
    localparam int C_GOOD   = 0;
    localparam int C_DROP   = 1;
    localparam int C_GAP    = 2;
    localparam int C_LAT    = 3;
    localparam int C_NULL   = 4;

    rx_state_t        state;
    rx_state_t        next_state;
    logic [5:0]       ctrl;
    logic [15:0]      subtype;
    logic [7:0]       hdr0;
    logic [7:0]       seq_hi;
    logic [1:0]       hdr_idx;
    logic [7:0]       seg_idx;
    logic [7:0]       seg_cnt;
    logic [7:0]       hold0;
    logic [7:0]       hold1;
    logic [1:0]       pend;
    logic             seg_null;
    logic             over;
    logic             seq_seen;
    logic [15:0]      seq_exp;
    logic [15:0]      last_seq;
    logic [15:0]      cnt [CNT_N];
    logic [31:0]      rd_data;

    subtype_if st_bus ();

    ts_subtype_classify u_classify (
        .st (st_bus.classify)
    );

    // ----------------------------------------
    // Header field decode
    // ----------------------------------------
    assign st_bus.code = subtype;
    wire logic        acc       = in_valid & in_ready;
    wire logic        in_hdr    = acc & (state == S_HDR);
    wire logic        hdr_last  = in_hdr & (hdr_idx == `HDR_LAST_IDX);
    wire logic        f_v       = hdr0[`HDR_V_BIT];                    // R12
    wire logic        f_s       = hdr0[`HDR_S_BIT];
    wire logic [1:0]  f_h       = hdr0[`HDR_H_MSB:`HDR_H_LSB];
    wire logic [2:0]  f_flow    = hdr0[`HDR_FLOW_MSB:0];               // X bit not decoded: R15
    wire logic [15:0] f_seq     = {seq_hi, in_data};                   // R24
    // Extended bits 10 and 11, or a set V bit, make a header unusable
    wire logic        conform   = ~f_v & ((f_h == `H_DATA) | (f_h == `H_LATENCY)); // R9 R23
    wire logic        is_data   = conform & (f_h == `H_DATA);          // R14
    wire logic        lat_hit   = hdr_last & conform & (f_h == `H_LATENCY); // R23
    wire logic        sess_ok   = ctrl[`CTRL_EN] & st_bus.valid;
    wire logic        wrong_typ = hdr_last & is_data & sess_ok & ~st_bus.is_single; // R8
    wire logic        flow_ok   = f_flow == ctrl[`CTRL_FLOW_MSB:`CTRL_FLOW_LSB]; // R22
    wire logic        take      = hdr_last & ~in_eop & is_data & sess_ok & st_bus.is_single & flow_ok; // R8
    wire logic        seq_chk   = take & f_s;                          // R13
    wire logic        gap       = seq_chk & seq_seen & (f_seq != seq_exp); // R16

    // ----------------------------------------
    // Payload segmentation decode
    // ----------------------------------------
    wire logic        pay       = acc & (state == S_PAY);
    wire logic        seg_end   = pay & (seg_idx == `TS_LAST_IDX);     // R10
    wire logic [12:0] pid       = {hold1[`TS_PIDHI_MSB:0], in_data};
    wire logic        at_pid    = pay & (seg_idx == `TS_PIDLO_IDX);
    wire logic        null_hit  = at_pid & (pid == `TS_NULL_PID) & ctrl[`CTRL_DROP_NULL]; // R21
    wire logic        release0  = at_pid & ~null_hit;
    wire logic        use_hold  = (pend != 2'h0) | release0;
    // Larger packets are only legal when the path allows a bigger MTU
    wire logic [7:0]  limit     = ctrl[`CTRL_LARGE_MTU] ? 8'(MAX_TS_LARGE) : 8'(MAX_TS_STD); // R19 R20
    wire logic        cnt_over  = seg_end & (seg_cnt >= limit);
    wire logic        pkt_end   = pay & in_eop;
    // A packet must end exactly on a segment boundary
    wire logic        pkt_bad   = pkt_end & (~seg_end | over | cnt_over); // R10 R17
    wire logic        early_end = (in_hdr & in_eop & ~hdr_last) | (acc & (state == S_IDLE) & in_sop & in_eop);
    wire logic        hdr_drop  = hdr_last & ~take & ~lat_hit;         // R9
    wire logic [1:0]  next_pend = release0 ? 2'h2 : ((pend != 2'h0) ? pend - 2'h1 : 2'h0);
    wire logic [CNT_N-1:0] cnt_inc;

    assign cnt_inc[C_GOOD] = pkt_end & ~pkt_bad;
    assign cnt_inc[C_DROP] = hdr_drop | early_end | pkt_bad;
    assign cnt_inc[C_GAP]  = gap;
    assign cnt_inc[C_LAT]  = lat_hit;
    assign cnt_inc[C_NULL] = null_hit;

    // ----------------------------------------
    // Receive state machine
    // ----------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            S_IDLE: begin
                if (acc & in_sop & ~in_eop) begin
                    next_state = S_HDR;
                end
            end
            S_HDR: begin
                if (hdr_last) begin
                    next_state = take ? S_PAY : (in_eop ? S_IDLE : S_DROP); // R9
                end else if (in_hdr & in_eop) begin
                    next_state = S_IDLE;
                end
            end
            S_PAY: begin
                if (pkt_end) begin
                    next_state = S_IDLE;
                end
            end
            S_DROP: begin
                if (acc & in_eop) begin
                    next_state = S_IDLE;
                end
            end
        endcase
    end

    // Header capture; the reserved byte is skipped on purpose
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state   <= S_IDLE;
            hdr0    <= 8'h00;
            seq_hi  <= 8'h00;
            hdr_idx <= 2'h0;
        end else begin
            state <= next_state;
            if (acc & (state == S_IDLE) & in_sop) begin
                hdr0    <= in_data;
                hdr_idx <= `HDR_RSV_IDX;
            end else if (in_hdr) begin
                hdr_idx <= hdr_idx + 2'h1;
            end
            if (in_hdr & (hdr_idx == `HDR_SEQHI_IDX)) begin
                seq_hi <= in_data;                                     // R24
            end
        end
    end

    // Segment position and per-packet segment count
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            seg_idx  <= 8'h00;
            seg_cnt  <= 8'h00;
            seg_null <= 1'b0;
            over     <= 1'b0;
        end else begin
            if (take | seg_end) begin
                seg_idx <= 8'h00;                                      // R10
            end else if (pay) begin
                seg_idx <= seg_idx + 8'h01;
            end
            seg_cnt  <= take ? 8'h00 : (seg_end ? seg_cnt + 8'h01 : seg_cnt); // R19
            over     <= take ? 1'b0 : (over | cnt_over);
            seg_null <= null_hit | (seg_null & ~seg_end);              // R21
        end
    end

    // Sync and PID bytes wait here until the PID says keep or discard
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold0 <= 8'h00;
            hold1 <= 8'h00;
            pend  <= 2'h0;
        end else begin
            pend <= next_pend;
            if (pay & (seg_idx == 8'h00)) begin
                hold0 <= in_data;
            end else if (use_hold) begin
                hold0 <= hold1;
            end
            if ((pay & (seg_idx == `TS_PIDHI_IDX)) | release0) begin
                hold1 <= in_data;
            end
        end
    end

    // ----------------------------------------
    // Segment output and packet events
    // ----------------------------------------
    // The source is stalled for two cycles while held bytes drain
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_ready <= 1'b1;
            ts_valid <= 1'b0;
            ts_data  <= 8'h00;
            ts_sos   <= 1'b0;
            ts_eos   <= 1'b0;
            pkt_done <= 1'b0;
            pkt_err  <= 1'b0;
        end else begin
            in_ready <= next_pend == 2'h0;
            ts_valid <= use_hold | (pay & (seg_idx > `TS_PIDLO_IDX) & ~seg_null); // R21
            ts_data  <= use_hold ? hold0 : in_data;
            ts_sos   <= release0;
            ts_eos   <= seg_end & ~seg_null;                           // R10
            pkt_done <= pkt_end;
            pkt_err  <= pkt_bad;                                       // R19
        end
    end

    // Sequence tracking, armed by the first valid sequence of a session
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            seq_seen <= 1'b0;
            seq_exp  <= 16'h0000;
            last_seq <= 16'h0000;
        end else begin
            seq_seen <= seq_chk | (seq_seen & ctrl[`CTRL_EN]);         // R13
            if (seq_chk) begin
                seq_exp  <= f_seq + 16'h0001;                          // R16
                last_seq <= f_seq;
            end
        end
    end

    // Event counters wrap silently; software reads differences
    for (genvar i = 0; i < CNT_N; i++) begin : g_cnt
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                cnt[i] <= 16'h0000;
            end else if (cnt_inc[i]) begin
                cnt[i] <= cnt[i] + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // APB slave, one wait state on every access
    // ----------------------------------------
    wire logic        setup_ok = psel & penable & ~pready;
    wire logic        wr       = psel & penable & pready & pwrite;
    wire logic        cnt_hit  = (paddr >= `REG_CNT_BASE) & (paddr < `REG_LAST_SEQ) & (paddr[1:0] == 2'h0);
    wire logic [7:0]  cnt_off  = paddr - `REG_CNT_BASE;
    wire logic [2:0]  cnt_sel  = cnt_off[4:2];
    wire logic [31:0] avp0     = {`AVP_MANDATORY, 1'b0, 4'h0, `AVP_LENGTH, VENDOR_ID}; // R1 R6
    wire logic [31:0] avp1     = {`AVP_ATTR_TYPE, subtype};            // R1 R6
    wire logic [31:0] status   = {28'h0, st_bus.is_down, st_bus.is_mpeg, st_bus.valid, teardown_request};
    wire logic        mapped   = cnt_hit | (paddr == `REG_CTRL) | (paddr == `REG_SUBTYPE) | (paddr == `REG_STATUS)
                                 | (paddr == `REG_AVP_WORD0) | (paddr == `REG_AVP_WORD1) | (paddr == `REG_LAST_SEQ);
    wire logic        clr_td   = wr & (paddr == `REG_STATUS) & pwdata[0];

    // Read selection
    always_comb begin
        rd_data = 32'h0000_0000;
        if (cnt_hit) begin
            rd_data = {16'h0000, cnt[cnt_sel]};
        end else begin
            case (paddr)
                `REG_CTRL:      rd_data = {26'h0, ctrl};
                `REG_SUBTYPE:   rd_data = {16'h0000, subtype};
                `REG_STATUS:    rd_data = status;
                `REG_AVP_WORD0: rd_data = avp0;
                `REG_AVP_WORD1: rd_data = avp1;
                `REG_LAST_SEQ:  rd_data = {16'h0000, last_seq};
                default:        rd_data = 32'h0000_0000;
            endcase
        end
    end

    // Bus answer registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_ok;
            if (setup_ok) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr <= ~mapped;
            end
        end
    end

    // Writable control; a teardown raised in the clearing cycle survives
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl             <= `CTRL_RESET;
            subtype          <= `SUBTYPE_RESET;
            teardown_request <= 1'b0;
        end else begin
            if (wr & (paddr == `REG_CTRL)) begin
                ctrl <= pwdata[5:0];
            end
            if (wr & (paddr == `REG_SUBTYPE)) begin
                subtype <= pwdata[15:0];                               // R6
            end
            teardown_request <= wrong_typ | (teardown_request & ~clr_td); // R8
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_bad_hdr_drop: assert property (hdr_last & ~conform |=> state != S_PAY) // R9
        else $error("non-conforming header entered payload");
    a_wrong_type: assert property (wrong_typ |=> teardown_request && state != S_PAY) // R8
        else $error("wrong session type did not raise teardown");
    a_flow_filter: assert property (hdr_last & ~flow_ok |=> state != S_PAY) // R22
        else $error("foreign flow accepted");
    a_seg_wrap: assert property (seg_end & ~in_eop |=> seg_idx == 8'h00 && state == S_PAY) // R10
        else $error("segment did not wrap after 188 bytes");
    a_null_hidden: assert property (null_hit |=> !ts_valid ##1 !ts_valid) // R21
        else $error("discarded null segment reached output");
    a_pid_drain: assert property (release0 |=> ts_sos && !in_ready ##1 ts_valid && !in_ready ##1 ts_valid && in_ready) // R10
        else $error("held segment bytes not drained in order");
    a_pkt_limit: assert property (pkt_end & seg_end & ~over & (seg_cnt < limit) |=> pkt_done && !pkt_err) // R19
        else $error("packet within segment limit flagged bad");
    a_seq_gap: assert property (gap |=> cnt[C_GAP] == $past(cnt[C_GAP]) + 16'h0001) // R16
        else $error("sequence gap not counted");
    a_lat_count: assert property (lat_hit |=> cnt[C_LAT] == $past(cnt[C_LAT]) + 16'h0001 && state != S_PAY) // R23
        else $error("latency header not counted or not diverted");
    a_avp_read: assert property (pready & psel & ~pwrite & (paddr == `REG_AVP_WORD0) |-> prdata[25:16] == `AVP_LENGTH) // R1
        else $error("subtype attribute length wrong");
endmodule // ts_sublayer_rx
`default_nettype wire

// [testbench/headend_model.sv]
// Headend core model streaming sublayer packets byte by byte
`default_nettype none
module headend_model (
    input  wire logic       clk,
    input  wire logic       in_ready,
    output var  logic       in_valid,
    output var  logic [7:0] in_data,
    output var  logic       in_sop,
    output var  logic       in_eop
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {in_valid, in_data, in_sop, in_eop} = '0;
    // Whole packet with no filler; slow mode idles after each byte
    task automatic send(input logic [7:0] q[$], input logic slow, output logic hung);
        hung = 1'b0;
        for (int i = 0; i < q.size(); i++) begin
            in_valid <= 1'b1;
            in_data  <= q[i];
            in_sop   <= (i == 0);
            in_eop   <= (i == q.size() - 1);
            @(posedge clk);
            for (int w = 0; w < 16 && !in_ready; w++) @(posedge clk);
            hung |= !in_ready; // A stall longer than the bound is a hang
            if (slow || i == q.size() - 1) begin
                in_valid <= 1'b0;
                in_data  <= ~q[i]; // Idle line must not repeat a stale byte
                @(posedge clk);
            end
        end
    endtask
endmodule // headend_model
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the transport sublayer receiver
`default_nettype none
`include "ts_sublayer_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0]  paddr = '0, in_data, ts_data;
    logic [31:0] pwdata = '0, prdata;
    logic        in_valid, in_sop, in_eop, in_ready, ts_valid, ts_sos, ts_eos, pkt_done, pkt_err;
    logic        teardown_request, exp_err = 0, lax = 0, slow = 0;
    logic [7:0]  exp_q[$];
    logic [15:0] lf = 16'h0061;
    int          fail_count = 0, n_tests = 0, ndone = 0, nul = -1, nb = 0;
    always #50 clk = ~clk;
    ts_sublayer_rx dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .in_valid, .in_data, .in_sop, .in_eop, .in_ready, .ts_valid, .ts_data, .ts_sos,
        .ts_eos, .pkt_done, .pkt_err, .teardown_request);
    headend_model hc_u (.clk, .in_ready, .in_valid, .in_data, .in_sop, .in_eop);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Master holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i <= 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
            if (i == 20) begin
                fail_count++;
                final_report();
            end
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, '0, r, e);
        chk(nm, x, r);
    endtask
    function automatic logic [7:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf[7:0];
    endfunction
    // Mode 0 delivered, 1 dropped, 2 malformed; PID kept off null unless asked
    task automatic pkt(input logic [7:0] b0, input logic [15:0] sq, input int ns, input int mode);
        logic [7:0] q[$];
        logic [7:0] b;
        logic       h;
        int         d0;
        d0  = ndone;
        lax = (mode == 2);
        q   = {b0, rnd(), sq[15:8], sq[7:0]};
        for (int s = 0; s < ns; s++) begin
            for (int i = 0; i < 188; i++) begin
                b = (i == 0) ? 8'h47 : rnd();
                if (i == 1) b = (s == nul) ? 8'h1F : (b & 8'hEF);
                if (i == 2 && s == nul) b = 8'hFF;
                q.push_back(b);
                if (mode == 0 && s != nul) exp_q.push_back(b);
            end
        end
        exp_err = (mode == 2);
        hc_u.send(q, slow, h);
        if (h) begin
            fail_count++;
            final_report();
        end
        repeat (3) @(posedge clk);
        if (mode != 1) chk("pkt_done", d0 + 1, ndone);
    endtask
    // Every delivered byte outside malformed mode, and every packet end, is compared with the model
    always @(posedge clk) begin
        if (ts_valid === 1'b1 && !lax) begin
            if (exp_q.size() == 0) chk("ts_extra", 0, 1);
            else chk("ts_data", exp_q.pop_front(), ts_data);
        end
        if (ts_sos === 1'b1) chk("ts_sos", 8'h47, ts_data);
        // Every delivered segment is whole, so its ends follow a running byte count
        if (ts_valid === 1'b1) begin
            chk("ts_eos", nb % 188 == 187, ts_eos);
            chk("ts_sos_pos", nb % 188 == 0, ts_sos);
            nb++;
        end
        if (pkt_done === 1'b1) begin
            ndone++;
            chk("pkt_err", exp_err, pkt_err);
        end
    end
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        final_report();
    end
    // Main sequence
    initial begin
        logic [31:0] r;
        logic        e, v, m, dn;
        static logic [7:0] hb[5] = '{8'h10, 8'h20, 8'h30, 8'h80, 8'h01};
        static int         cn[5] = '{6, 5, 1, 1, 1};
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(`REG_CTRL, '0, "ctrl");
        rd(`REG_SUBTYPE, 32'h1, "subtype");
        rd(`REG_AVP_WORD0, 32'h8008A5A5, "avp0");
        apb(1'b0, 8'hFC, '0, r, e);
        chk("unmapped_err", 1, e);
        chk("unmapped_rd", 0, r);
        for (int c = 0; c < 24; c++) begin
            v  = c inside {[1:4], [6:16], [18:22]};
            m  = c inside {1, 3, 18, 19, 20};
            dn = c inside {[1:4], 13, 14, 16, 19, 21};
            wr(`REG_SUBTYPE, c);
            rd(`REG_AVP_WORD1, {16'h0011, c[15:0]}, "avp1");
            apb(1'b0, `REG_STATUS, '0, r, e);
            chk("status", v ? {dn, m, 2'b10} : 4'h0, v ? r[3:0] : {2'b00, r[1:0]});
        end
        wr(`REG_SUBTYPE, 32'h1);
        wr(`REG_CTRL, 32'h1);
        pkt(8'h40, 16'h1234, 2, 0);
        pkt(8'h48, 16'h1235, 1, 0);
        pkt(8'h40, 16'h1238, 1, 0);
        pkt(8'h00, 16'h0000, 1, 0);
        foreach (hb[i]) pkt(hb[i], 16'h0000, 1, 1);
        slow = 1;
        pkt(8'h40, 16'h1239, 7, 0);
        slow = 0;
        pkt(8'h00, 16'h0000, 8, 2);
        wr(`REG_CTRL, 32'h3);
        nul = 1;
        pkt(8'h40, 16'h123A, 3, 0);
        nul = -1;
        foreach (cn[i]) rd(`REG_CNT_BASE + 8'(4 * i), cn[i], "counter");
        rd(`REG_LAST_SEQ, 32'h123A, "last_seq");
        wr(`REG_CTRL, 32'h15);
        pkt(8'h02, 16'h0000, 8, 0);
        wr(`REG_SUBTYPE, 32'h2);
        pkt(8'h40, 16'h123B, 1, 1);
        chk("teardown", 1, teardown_request);
        rd(`REG_STATUS, 32'hB, "status_td");
        wr(`REG_STATUS, 32'h1);
        rd(`REG_STATUS, 32'hA, "status_clr");
        wr(`REG_SUBTYPE, 32'h5);
        pkt(8'h40, 16'h123C, 1, 1);
        chk("no_teardown", 0, teardown_request);
        chk("leftover", 0, exp_q.size());
        $display("all tests ended");
        final_report();
    end
endmodule // tb
`default_nettype wire
